// *** hw/tcc_pkg.sv ***
// tcc_pkg: constants shared by the timer compare/capture device end and its cpu-side end.
// assumes both ends run on one clock, clk_sys at 100 MHz.
package tcc_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int NCH    = 2;
  localparam int NFLG   = 3;
  // ==========================================================
  // device byte map on the 8-bit bus
  localparam logic [3:0] A_CNT_L  = 4'h0;
  localparam logic [3:0] A_CNT_H  = 4'h1;
  localparam logic [3:0] A_CMPA_L = 4'h2;
  localparam logic [3:0] A_CMPA_H = 4'h3;
  localparam logic [3:0] A_CMPB_L = 4'h4;
  localparam logic [3:0] A_CMPB_H = 4'h5;
  localparam logic [3:0] A_CAP_L  = 4'h6;
  localparam logic [3:0] A_CAP_H  = 4'h7;
  localparam logic [3:0] A_ACT    = 4'h8;  // [1:0] channel a, [3:2] channel b
  localparam logic [3:0] A_MODE   = 4'h9;  // [3:0] waveform mode
  localparam logic [3:0] A_FORCE  = 4'hA;  // [1:0] force strobes, write only
  localparam logic [3:0] A_FLAGS  = 4'hB;  // [0] cmp a, [1] cmp b, [2] capture
  localparam logic [3:0] A_IEN    = 4'hC;
  localparam logic [3:0] A_PORT   = 4'hD;  // [1:0] port value, [3:2] direction
  localparam int FLG_CAP = 2;
  // ==========================================================
  // waveform modes and output actions
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_FP8    = 4'h5;
  localparam logic [3:0] WGM_FP9    = 4'h6;
  localparam logic [3:0] WGM_FP10   = 4'h7;
  localparam logic [3:0] WGM_CTC_C  = 4'hC;
  localparam logic [3:0] WGM_RSVD   = 4'hD;
  localparam logic [3:0] WGM_FP_C   = 4'hE;
  localparam logic [3:0] WGM_FP_A   = 4'hF;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8     = 16'h00FF;
  localparam logic [15:0] TOP_9     = 16'h01FF;
  localparam logic [15:0] TOP_10    = 16'h03FF;
  localparam logic [15:0] RST_W16   = 16'h0000;
  localparam logic [7:0]  RST_B     = 8'h00;
  // ==========================================================
  // cpu-side register map over axi4-lite
  localparam logic [3:0] H_CMD  = 4'h0;  // [7:0] data, [11:8] addr, [12] write, [13] read
  localparam logic [3:0] H_STAT = 4'h4;  // [7:0] read data, [8] busy, [11:9] irq lines
  localparam logic [3:0] H_ACK  = 4'h8;  // [2:0] interrupt acknowledge strobes
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int CMD_WR = 12;
  localparam int CMD_RD = 13;
endpackage : tcc_pkg

// *** hw/tcc_bus_if.sv ***
// tcc_bus_if: 8-bit cpu bus between the timer device end and the cpu end.
// assumes both ends share clk_sys; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface tcc_bus_if;
  logic [3:0] addr;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] irq_req;
  logic [2:0] irq_ack;
  modport dev (input addr, input wr_en, input rd_en, input wdata, input irq_ack,
               output rdata, output irq_req);
  modport cpu (output addr, output wr_en, output rd_en, output wdata, output irq_ack,
               input rdata, input irq_req);
endinterface : tcc_bus_if

// *** hw/tcc_dev.sv ***
// tcc_dev: 16-bit timer compare channels a/b, output state logic and capture register.
// assumes timer_tick is a one-cycle prescaled timer clock enable on clk_sys.
// Function
// - new capture overwrites unread captured value
// - software clears capture flag after edge change
// - compare full counter with each compare value
// - compare flag sets at next timer tick
// - enabled flag requests interrupt, cleared on service
// - writing one clears flag, zero keeps
// - channel a can set counter top
// - double buffering only in pwm modes
// - buffer moves to compare only at top
// - cpu reaches buffer or compare, cpu-only changes
// - compare reads bypass the holding register
// - software writes high byte before low
// - low write copies holding byte same cycle
// - force strobe acts like match in non-pwm modes, no flag
// - counter write blocks match next tick
// - never write counter equal variable top
// - never write bottom while counting down
// - output state survives mode changes
// - action select unbuffered, next match uses it
// - reset clears output state
// - active action overrides port, direction still rules
// - action zero leaves output state unchanged
// - toggle action toggles on each match in non-pwm modes; pwm modes keep output state
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module tcc_dev (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // cpu bus
  tcc_bus_if.dev          bus,
  // timer side
  input  wire logic       timer_tick,
  input  wire logic       capture_pin,
  // compare pins
  output logic [1:0]      pin_out,
  output logic [1:0]      pin_oe
);
  // ==========================================================
  // state
  logic [15:0] cnt_q, cap_q;
  logic [15:0] cmp_q  [2];
  logic [15:0] cbuf_q [2];
  logic [3:0]  mode_q, act_q, port_q;
  logic [2:0]  flg_q, ien_q, irq_q;
  logic [1:0]  mt_q, oc_q, pin_out_q, pin_oe_q;
  logic        blk_q;
  logic        cp_s1_q, cp_s2_q, cp_s3_q;
  logic [7:0]  temp_q, rdata_q;

  // ==========================================================
  // decode
  wire       tick     = timer_tick;
  wire       wr       = bus.wr_en;
  wire       rd       = bus.rd_en;
  wire [7:0] wd       = bus.wdata;
  wire       wr_cnt_l = wr && bus.addr == tcc_pkg::A_CNT_L;
  wire       wr_cap_l = wr && bus.addr == tcc_pkg::A_CAP_L;
  wire       wr_hi    = wr && (bus.addr == tcc_pkg::A_CNT_H || bus.addr == tcc_pkg::A_CMPA_H ||
                               bus.addr == tcc_pkg::A_CMPB_H || bus.addr == tcc_pkg::A_CAP_H);
  wire       rd_cnt_l = rd && bus.addr == tcc_pkg::A_CNT_L;
  wire       rd_cap_l = rd && bus.addr == tcc_pkg::A_CAP_L;
  wire       wr_flg   = wr && bus.addr == tcc_pkg::A_FLAGS;
  wire       wr_force = wr && bus.addr == tcc_pkg::A_FORCE;
  wire [1:0] wr_cmp_l = {wr && bus.addr == tcc_pkg::A_CMPB_L, wr && bus.addr == tcc_pkg::A_CMPA_L};
  wire [15:0] wr_word = {temp_q, wd};

  // non-pwm: normal, both ctc modes and the reserved code; the other twelve are pwm
  wire is_pwm = !(mode_q == tcc_pkg::WGM_NORMAL || mode_q == tcc_pkg::WGM_CTC_A ||
                  mode_q == tcc_pkg::WGM_CTC_C || mode_q == tcc_pkg::WGM_RSVD);
  wire var_top = mode_q == tcc_pkg::WGM_CTC_A || mode_q == tcc_pkg::WGM_FP_A ||
                 mode_q == tcc_pkg::WGM_CTC_C || mode_q == tcc_pkg::WGM_FP_C;
  wire cap_wr_ok = mode_q == tcc_pkg::WGM_CTC_C || mode_q == tcc_pkg::WGM_FP_C;

  // channel a or the capture register may define top
  wire [15:0] top_val =
      (mode_q == tcc_pkg::WGM_CTC_A || mode_q == tcc_pkg::WGM_FP_A) ? cmp_q[0] :
      cap_wr_ok                     ? cap_q :
      (mode_q == tcc_pkg::WGM_FP8)  ? tcc_pkg::TOP_8 :
      (mode_q == tcc_pkg::WGM_FP9)  ? tcc_pkg::TOP_9 :
      (mode_q == tcc_pkg::WGM_FP10) ? tcc_pkg::TOP_10 : tcc_pkg::TOP_MAX;
  wire at_top = cnt_q == top_val;
  // a blocked top in a variable-top mode lets the counter run on to the maximum
  wire wrap   = at_top && !(blk_q && var_top);

  wire cap_edge = cp_s2_q && !cp_s3_q;
  wire [2:0] flg_set = {cap_edge, tick ? mt_q : 2'b00};
  wire [2:0] flg_clr = (wr_flg ? wd[2:0] : 3'b000) | bus.irq_ack;

  wire [7:0] rd_val =
      (bus.addr == tcc_pkg::A_CNT_L)  ? cnt_q[7:0] :
      (bus.addr == tcc_pkg::A_CNT_H)  ? temp_q[7:0] :
      (bus.addr == tcc_pkg::A_CMPA_L) ? (is_pwm ? cbuf_q[0][7:0]  : cmp_q[0][7:0]) :
      (bus.addr == tcc_pkg::A_CMPA_H) ? (is_pwm ? cbuf_q[0][15:8] : cmp_q[0][15:8]) :
      (bus.addr == tcc_pkg::A_CMPB_L) ? (is_pwm ? cbuf_q[1][7:0]  : cmp_q[1][7:0]) :
      (bus.addr == tcc_pkg::A_CMPB_H) ? (is_pwm ? cbuf_q[1][15:8] : cmp_q[1][15:8]) :
      (bus.addr == tcc_pkg::A_CAP_L)  ? cap_q[7:0] :
      (bus.addr == tcc_pkg::A_CAP_H)  ? temp_q[7:0] :
      (bus.addr == tcc_pkg::A_ACT)    ? {4'h0, act_q} :
      (bus.addr == tcc_pkg::A_MODE)   ? {4'h0, mode_q} :
      (bus.addr == tcc_pkg::A_FLAGS)  ? {5'h00, flg_q} :
      (bus.addr == tcc_pkg::A_IEN)    ? {5'h00, ien_q} :
      (bus.addr == tcc_pkg::A_PORT)   ? {4'h0, port_q} : tcc_pkg::RST_B;

  // ==========================================================
  // counter, holding byte, capture
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q <= tcc_pkg::RST_W16;
      blk_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_cnt_l) begin
        cnt_q <= wr_word;  // cpu write wins over counting
        blk_q <= 1'b1;
      end else if (tick) begin
        cnt_q <= wrap ? tcc_pkg::RST_W16 : 16'(cnt_q + 16'h0001);
        blk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      temp_q <= tcc_pkg::RST_B;
    end else if (clk_en) begin
      if (wr_hi)
        temp_q <= wd;
      else if (rd_cnt_l)
        temp_q <= cnt_q[15:8];
      else if (rd_cap_l)
        temp_q <= cap_q[15:8];
    end
  end

  // capture pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cp_s1_q <= 1'b0;
      cp_s2_q <= 1'b0;
      cp_s3_q <= 1'b0;
      cap_q   <= tcc_pkg::RST_W16;
    end else if (clk_en) begin
      cp_s1_q <= capture_pin;
      cp_s2_q <= cp_s1_q;
      cp_s3_q <= cp_s2_q;
      if (cap_edge)
        cap_q <= cnt_q;  // unread value simply lost
      else if (wr_cap_l && cap_wr_ok)
        cap_q <= wr_word;
    end
  end

  // ==========================================================
  // control, flags, bus answer and pins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q    <= 4'h0;
      act_q     <= 4'h0;
      port_q    <= 4'h0;
      ien_q     <= 3'h0;
      flg_q     <= 3'h0;
      irq_q     <= 3'h0;
      rdata_q   <= tcc_pkg::RST_B;
      pin_out_q <= 2'h0;
      pin_oe_q  <= 2'h0;
    end else if (clk_en) begin
      if (wr && bus.addr == tcc_pkg::A_MODE) mode_q <= wd[3:0];
      if (wr && bus.addr == tcc_pkg::A_ACT)  act_q  <= wd[3:0];  // no shadow copy
      if (wr && bus.addr == tcc_pkg::A_PORT) port_q <= wd[3:0];
      if (wr && bus.addr == tcc_pkg::A_IEN)  ien_q  <= wd[2:0];
      // a set in the clearing cycle wins
      flg_q     <= flg_set | (flg_q & ~flg_clr);
      irq_q     <= flg_q & ien_q;
      if (rd) rdata_q <= rd_val;
      pin_oe_q  <= port_q[3:2];
      pin_out_q <= {act_q[3:2] != tcc_pkg::ACT_NONE ? oc_q[1] : port_q[1],
                    act_q[1:0] != tcc_pkg::ACT_NONE ? oc_q[0] : port_q[0]};
    end
  end

  // ==========================================================
  // per-channel compare, buffer and output state
  for (genvar i = 0; i < tcc_pkg::NCH; i++) begin : g_ch
    wire [1:0] act   = act_q[2*i +: 2];
    wire       eq    = cnt_q == cmp_q[i];
    wire       hit   = tick && mt_q[i];
    wire       force_hit = wr_force && wd[i] && !is_pwm;
    // non-pwm actions on a match or force; fast-pwm sets/clears on match and top
    wire       oc_np = (act == tcc_pkg::ACT_TOGGLE) ? !oc_q[i] :
                       (act == tcc_pkg::ACT_CLEAR)  ? 1'b0 :
                       (act == tcc_pkg::ACT_SET)    ? 1'b1 : oc_q[i];
    wire       pw_top = tick && wrap;
    wire       oc_pw = (act == tcc_pkg::ACT_CLEAR) ? (hit ? 1'b1 : 1'b0) :
                       (act == tcc_pkg::ACT_SET)   ? (hit ? 1'b0 : 1'b1) : oc_q[i];

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        mt_q[i]   <= 1'b0;
        oc_q[i]   <= 1'b0;
        cmp_q[i]  <= tcc_pkg::RST_W16;
        cbuf_q[i] <= tcc_pkg::RST_W16;
      end else if (clk_en) begin
        if (tick) mt_q[i] <= eq && !blk_q;
        // mode changes never touch oc_q by themselves
        if (!is_pwm && (hit || force_hit))
          oc_q[i] <= oc_np;
        else if (is_pwm && (hit || pw_top))
          oc_q[i] <= oc_pw;
        if (wr_cmp_l[i]) begin
          cbuf_q[i] <= wr_word;
          if (!is_pwm) cmp_q[i] <= wr_word;
        end else if (is_pwm && pw_top) begin
          cmp_q[i] <= cbuf_q[i];  // only at top, so no odd pulse
        end
      end
    end
  end

  assign bus.rdata   = rdata_q;
  assign bus.irq_req = irq_q;
  assign pin_out     = pin_out_q;
  assign pin_oe      = pin_oe_q;
endmodule : tcc_dev

// *** hw/tcc_cpu.sv ***
// tcc_cpu: cpu end of the timer bus, driven by software through axi4-lite registers.
// assumes clk_sys shared with the device end; one bus access per command.
`timescale 1ns/1ps
module tcc_cpu (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // axi4-lite slave
  input  wire logic [3:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [3:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // timer bus
  tcc_bus_if.cpu          bus
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ISSUE = 3'b010, ST_WAIT = 3'b100} tcc_st_e;
  tcc_st_e     st_q;
  logic        aw_q, w_q, bv_q, rv_q, ws_q;
  logic [3:0]  awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [3:0]  addr_q;
  logic [7:0]  data_q, res_q;
  logic        wr_q, rd_en_q;
  logic [2:0]  ack_q;

  // ==========================================================
  // decode
  wire do_wr   = aw_q && w_q && !bv_q;
  wire cmd_wr  = do_wr && awa_q == tcc_pkg::H_CMD;
  wire ack_wr  = do_wr && awa_q == tcc_pkg::H_ACK;
  wire busy    = st_q != ST_IDLE;
  wire map_wr  = awa_q == tcc_pkg::H_CMD || awa_q == tcc_pkg::H_ACK;
  wire do_rd   = s_axi_arvalid && !rv_q;
  wire [31:0] stat = {20'h00000, bus.irq_req, busy, res_q};
  wire map_rd  = s_axi_araddr == tcc_pkg::H_STAT;

  // ==========================================================
  // axi4-lite slave: address and data taken in either order
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;  ws_q <= 1'b0;
      awa_q <= 4'h0;  wd_q <= 32'h00000000;  rd_q <= 32'h00000000;
      bresp_q <= tcc_pkg::RESP_OK;  rresp_q <= tcc_pkg::RESP_OK;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb[0];  // strobe may drop once w is taken
      end
      if (do_wr) begin
        bv_q    <= 1'b1;
        bresp_q <= map_wr ? tcc_pkg::RESP_OK : tcc_pkg::RESP_ERR;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
      if (do_rd) begin
        rv_q    <= 1'b1;
        rd_q    <= map_rd ? stat : 32'h00000000;
        rresp_q <= map_rd ? tcc_pkg::RESP_OK : tcc_pkg::RESP_ERR;
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bus sequencer: a command given while busy is dropped
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;  addr_q <= 4'h0;  data_q <= 8'h00;  res_q <= 8'h00;
      wr_q <= 1'b0;  rd_en_q <= 1'b0;  ack_q <= 3'h0;
    end else if (clk_en) begin
      wr_q    <= 1'b0;
      rd_en_q <= 1'b0;
      ack_q   <= (ack_wr && ws_q) ? wd_q[2:0] : 3'h0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_wr && (wd_q[tcc_pkg::CMD_WR] || wd_q[tcc_pkg::CMD_RD])) begin
            addr_q  <= wd_q[11:8];
            data_q  <= wd_q[7:0];
            wr_q    <= wd_q[tcc_pkg::CMD_WR];
            rd_en_q <= !wd_q[tcc_pkg::CMD_WR];
            st_q    <= ST_ISSUE;
          end
        end
        ST_ISSUE: st_q <= ST_WAIT;
        ST_WAIT: begin
          res_q <= bus.rdata;
          st_q  <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign s_axi_awready = s_axi_awvalid && !aw_q;
  assign s_axi_wready  = s_axi_wvalid && !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = do_rd;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rresp_q;
  assign bus.addr      = addr_q;
  assign bus.wdata     = data_q;
  assign bus.wr_en     = wr_q;
  assign bus.rd_en     = rd_en_q;
  assign bus.irq_ack   = ack_q;
endmodule : tcc_cpu

// *** dv/tcc_monitor.sv ***
// tcc_monitor: assertions on the 8-bit timer bus between the cpu end and the device end.
// assumes tb instantiates it beside the bus interface; one clock, sync active-low reset.
`timescale 1ns/1ps
module tcc_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // timer bus
  input wire logic [3:0] addr,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [2:0] irq_req,
  input wire logic [2:0] irq_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // shadow of compare a; only trusted while the holding byte is known
  logic [7:0]  hold_q;
  logic        hvld_q;
  logic [15:0] cmpa_q;
  logic        cvld_q;
  logic [2:0]  ien_q;
  wire         wr_high = wr_en && addr[0] && !addr[3];
  wire         rd_load = rd_en && (addr == tcc_pkg::A_CNT_L || addr == tcc_pkg::A_CAP_L);
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hvld_q <= 1'b0;
      cvld_q <= 1'b0;
      ien_q  <= 3'h0;
    end else begin
      if (wr_high) hold_q <= wdata;
      hvld_q <= wr_high | (hvld_q & !rd_load);
      if (wr_en && addr == tcc_pkg::A_CMPA_L) cmpa_q <= {hold_q, wdata};
      if (wr_en && addr == tcc_pkg::A_CMPA_L) cvld_q <= hvld_q;
      else if (wr_en && addr == tcc_pkg::A_MODE) cvld_q <= 1'b0;
      if (wr_en && addr == tcc_pkg::A_IEN) ien_q <= wdata[2:0];
    end
  end
  // ==========================================================
  // assertions
  strobe_pulse_a: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en))
    else $error("bus strobe held beyond one cycle");
  strobe_excl_a: assert property (!(wr_en && rd_en))
    else $error("read and write strobes together");
  rdata_hold_a: assert property (!rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  irq_mask_a: assert property ((irq_req & ~$past(ien_q)) == 3'h0)
    else $error("interrupt request while disabled");
  ack_clear_a: assert property (irq_ack[0] |-> ##2 !irq_req[0])
    else $error("acknowledge did not clear request");
  w1c_clear_a: assert property (wr_en && addr == tcc_pkg::A_FLAGS && wdata[0] |-> ##2 !irq_req[0])
    else $error("write one did not clear flag");
  cmp_low_a: assert property (rd_en && cvld_q && addr == tcc_pkg::A_CMPA_L |=> rdata == cmpa_q[7:0])
    else $error("compare low byte readback wrong");
  cmp_high_a: assert property (rd_en && cvld_q && addr == tcc_pkg::A_CMPA_H |=> rdata == cmpa_q[15:8])
    else $error("compare high byte readback wrong");
  cov_cmp_wr: cover property (wr_en && addr == tcc_pkg::A_CMPA_L && hvld_q);
  cov_irq: cover property ($rose(irq_req[0]));
  cov_ack: cover property (irq_ack[0]);
endmodule : tcc_monitor

// *** dv/tb.sv ***
// tb: drives the cpu end over axi4-lite and the device timer inputs, checks pins and readback.
// assumes both ends face each other over tcc_bus_if; timer ticks are issued only by the bench.
`timescale 1ns/1ps
module tb;
  logic        clk_sys, reset_n, timer_tick, capture_pin;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, s;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r, pin_out, pin_oe;
  logic [7:0]  q;
  logic [15:0] v, x, y;
  int          err_count, samples_checked, seed, i;
  tcc_bus_if bus_if ();
  tcc_dev u_tcc_dev (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .bus(bus_if),
    .timer_tick(timer_tick), .capture_pin(capture_pin), .pin_out(pin_out), .pin_oe(pin_oe));
  tcc_cpu u_tcc_cpu (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus_if));
  tcc_monitor u_tcc_monitor (.clk_sys(clk_sys), .reset_n(reset_n), .addr(bus_if.addr), .wr_en(bus_if.wr_en),
    .rd_en(bus_if.rd_en), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .irq_req(bus_if.irq_req),
    .irq_ack(bus_if.irq_ack));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // checking and bus tasks; every task is entered just after a rising edge
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd
  // one device byte access through the command register, then poll until idle
  task automatic dev(input logic wr, input logic [3:0] a, input logic [7:0] d);
    axi_wr(tcc_pkg::H_CMD, {18'h0, !wr, wr, a, d});
    do begin
      axi_rd(tcc_pkg::H_STAT);
    end while (s[8] !== 1'b0);
    q = s[7:0];
  endtask : dev
  task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
    dev(1'b1, 4'(lo + 4'h1), d[15:8]);
    dev(1'b1, lo, d[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] lo);
    dev(1'b0, lo, 8'h00);
    v[7:0] = q;
    dev(1'b0, 4'(lo + 4'h1), 8'h00);
    v[15:8] = q;
  endtask : rd16
  task automatic tick(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge clk_sys);
      timer_tick <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : tick
  task automatic flag_is(input int b, input logic e);
    dev(1'b0, tcc_pkg::A_FLAGS, 8'h00);
    chk(32'(q[b]), 32'(e));
  endtask : flag_is
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h65ca6d47;
    reset_n = 1'b0; timer_tick = 1'b0; capture_pin = 1'b0; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'hF;
    wdata = 32'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'({pin_out, pin_oe}), 32'h0);
    axi_rd(4'hC);
    chk(32'(r), 32'(tcc_pkg::RESP_ERR));
    $display("test reset done");
    // active register in normal mode, buffer in pwm mode; first pass uses extreme values
    for (i = 0; i < 6; i++) begin
      x = (i == 0) ? 16'hFFFF : 16'($random(seed));
      y = (i == 0) ? 16'h0000 : 16'($random(seed));
      dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_NORMAL));
      wr16(tcc_pkg::A_CMPA_L, x);
      dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_FP_C));
      wr16(tcc_pkg::A_CMPA_L, y);
      rd16(tcc_pkg::A_CMPA_L);
      chk(32'(v), 32'(y));
      dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_NORMAL));
      rd16(tcc_pkg::A_CMPA_L);
      chk(32'(v), 32'(x));
    end
    // active register takes the buffer only at the fixed top
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_FP8));
    wr16(tcc_pkg::A_CNT_L, 16'h00FE);
    tick(1);
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_NORMAL));
    rd16(tcc_pkg::A_CMPA_L);
    chk(32'(v), 32'(x));
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_FP8));
    tick(1);
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_NORMAL));
    rd16(tcc_pkg::A_CMPA_L);
    chk(32'(v), 32'(y));
    $display("test compare access done");
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_CTC_A));
    wr16(tcc_pkg::A_CMPA_L, 16'h0005);
    wr16(tcc_pkg::A_CNT_L, 16'h0003);
    dev(1'b1, tcc_pkg::A_FLAGS, 8'h07);
    dev(1'b1, tcc_pkg::A_IEN, 8'h01);
    tick(3);
    flag_is(0, 1'b0);
    tick(1);
    flag_is(0, 1'b1);
    rd16(tcc_pkg::A_CNT_L);
    chk(32'(v), 32'h1);
    axi_rd(tcc_pkg::H_STAT);
    chk(32'(s[9]), 32'h1);
    axi_wr(tcc_pkg::H_ACK, 32'h1);
    flag_is(0, 1'b0);
    // counter written to the compare value: that match is swallowed
    wr16(tcc_pkg::A_CNT_L, 16'h0005);
    tick(2);
    flag_is(0, 1'b0);
    wr16(tcc_pkg::A_CNT_L, 16'h0004);
    tick(3);
    flag_is(0, 1'b1);
    dev(1'b1, tcc_pkg::A_FLAGS, 8'h00);
    flag_is(0, 1'b1);
    dev(1'b1, tcc_pkg::A_FLAGS, 8'h01);
    flag_is(0, 1'b0);
    $display("test match flag done");
    dev(1'b1, tcc_pkg::A_PORT, 8'h04);
    dev(1'b1, tcc_pkg::A_ACT, 8'h00);
    dev(1'b1, tcc_pkg::A_FORCE, 8'h01);
    chk(32'({pin_oe[0], pin_out[0]}), 32'h2);
    dev(1'b1, tcc_pkg::A_ACT, 8'(tcc_pkg::ACT_TOGGLE));
    chk(32'(pin_out[0]), 32'h0);
    dev(1'b1, tcc_pkg::A_FORCE, 8'h01);
    chk(32'(pin_out[0]), 32'h1);
    flag_is(0, 1'b0);
    wr16(tcc_pkg::A_CNT_L, 16'h0004);
    tick(3);
    @(posedge clk_sys);
    chk(32'(pin_out[0]), 32'h0);
    dev(1'b1, tcc_pkg::A_FLAGS, 8'h01);
    dev(1'b1, tcc_pkg::A_ACT, 8'(tcc_pkg::ACT_SET));
    dev(1'b1, tcc_pkg::A_FORCE, 8'h01);
    chk(32'(pin_out[0]), 32'h1);
    dev(1'b1, tcc_pkg::A_MODE, 8'(tcc_pkg::WGM_NORMAL));
    chk(32'(pin_out[0]), 32'h1);
    dev(1'b1, tcc_pkg::A_ACT, 8'h00);
    dev(1'b1, tcc_pkg::A_FORCE, 8'h01);
    dev(1'b1, tcc_pkg::A_ACT, 8'(tcc_pkg::ACT_CLEAR));
    chk(32'(pin_out[0]), 32'h1);
    dev(1'b1, tcc_pkg::A_FORCE, 8'h01);
    chk(32'(pin_out[0]), 32'h0);
    dev(1'b1, tcc_pkg::A_ACT, 8'h00);
    dev(1'b1, tcc_pkg::A_PORT, 8'h05);
    chk(32'(pin_out[0]), 32'h1);
    dev(1'b1, tcc_pkg::A_PORT, 8'h01);
    chk(32'(pin_oe[0]), 32'h0);
    $display("test output state done");
    // two captures with no read between: the later time-stamp wins
    x = 16'($random(seed));
    y = ~x;
    wr16(tcc_pkg::A_CNT_L, x);
    capture_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    capture_pin <= 1'b0;
    wr16(tcc_pkg::A_CNT_L, y);
    capture_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    capture_pin <= 1'b0;
    rd16(tcc_pkg::A_CAP_L);
    chk(32'(v), 32'(y));
    flag_is(tcc_pkg::FLG_CAP, 1'b1);
    dev(1'b1, tcc_pkg::A_FLAGS, 8'h04);
    flag_is(tcc_pkg::FLG_CAP, 1'b0);
    $display("test capture done");
    test_done();
  end
endmodule : tb
